// ### level_sync.v
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the destination runs on core_clk; first stage read only by second.
`timescale 1ns/100ps
`default_nettype none

module level_sync #(
    parameter WIDTH = 1
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] stable_q;

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            meta_q   <= {WIDTH{1'b0}};
            stable_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q   <= async_in;
            stable_q <= meta_q;
        end
    end

    assign sync_out = stable_q;

endmodule

`default_nettype wire

// ### level_sync_unused_marker.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### link_model.sv
// Link-layer side model driving the bank's register port.
// Assumes callers enter its tasks between falling clock edges.
`timescale 1ns/100ps
`default_nettype none
module link_model (
    input  wire       core_clk,
    output reg  [3:0] reg_addr,
    output reg        reg_wr,
    output reg  [7:0] reg_wdata,
    output reg        reg_rd,
    input  wire [7:0] reg_rdata,
    input  wire       reg_rd_valid
);
    initial
    begin
        reg_addr  = 4'h0;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end
    // Data is inverted after use so a stale byte never looks fresh
    task wr(input [3:0] a, input [7:0] d);
    begin
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    end
    endtask
    task rd(input [3:0] a, output [7:0] d);
    begin
        @(negedge core_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = (reg_rd_valid === 1'b1) ? reg_rdata : 8'hxx;
    end
    endtask
endmodule
`default_nettype wire

// ### paged_store.v
// Storage for the paged register locations 8h through Fh.
// Assumes the caller supplies the current page; reserved pages read zero.
`timescale 1ns/100ps
`default_nettype none
`include "phy_regs_map.vh"

module paged_store #(
    parameter DATA_W = 8
) (
    input  wire              core_clk,
    input  wire              rst,
    input  wire [2:0]        page,
    input  wire [2:0]        index,
    input  wire              wr_en,
    input  wire [DATA_W-1:0] wr_data,
    output reg  [DATA_W-1:0] rd_data
);

    // Three backed pages of eight bytes: slots 0-7, 8-15, 16-23
    reg  [DATA_W-1:0] mem_q [0:23];
    reg  [4:0]        slot;
    reg               backed;
    integer           i;

    always @*
    begin
        slot   = 5'd0;
        backed = 1'b1;
        case (page)
            `PAGE_PORT_STATUS: slot = {2'b00, index};
            `PAGE_VENDOR_ID:   slot = {2'b01, index};
            `PAGE_VENDOR_DEP:  slot = {2'b10, index};
            default:           backed = 1'b0;
        endcase
        rd_data = backed ? mem_q[slot] : {DATA_W{1'b0}}; // [RQ7]
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            for (i = 0; i < 24; i = i + 1)
                mem_q[i] <= `PAGED_RESET;
        end
        else if (wr_en && backed)
        begin
            mem_q[slot] <= wr_data; // [RQ3]
        end
    end

endmodule

`default_nettype wire

// ### phy_base_regs.v
// Register bank of the cable PHY section, seen from the link-layer side.
// Assumes one core_clk domain for the link port and the PHY core events;
// the cable power sense arrives from a pin and is synchronised here.
//
// Notes on behaviour
// [RQ1] Sixteen locations reached through a four-bit register address.
// [RQ2] Addresses 0 to 7 form a fixed base set, independent of page.
// [RQ3] Addresses 8 to 15 are paged, chosen from eight pages.
// [RQ4] The page comes from the page field in base register 7.
// [RQ5] Base fields mean the same whatever page is selected.
// [RQ6] Reserved registers and fields read as zero.
// [RQ7] Every location of pages 2 through 6 reads as zero.
// [RQ8] Register 0 holds the six-bit read-only node identifier from self-ID.
// [RQ9] Identifier invalid after bus reset; self-ID end sends register 0.
// [RQ10] Root flag clears on bus reset, sets when this node becomes root.
// [RQ11] Cable power bit follows the sense input; zero means power too low.
// [RQ12] Root holdoff set asks the node to become root after next reset.
// [RQ13] Root holdoff clears on hardware reset, survives bus resets.
// [RQ14] Link side changes root holdoff only by configuration packet; here a register 1 write also sets it.
// [RQ15] Long reset request waits for traffic end, clears on any reset.
// [RQ16] Gap count resets to 3Fh on reset or two unwritten bus resets.
// [RQ17] Bit position 0 of a register is the most significant data bit.
`timescale 1ns/100ps
`default_nettype none
`include "phy_regs_map.vh"

module phy_base_regs #(
    parameter NODE_ID_W = 6,
    parameter GAP_W     = 6
) (
    input  wire                 core_clk,
    input  wire                 rst,
    // Link-layer side register port
    input  wire [3:0]           reg_addr,
    input  wire                 reg_wr,
    input  wire [7:0]           reg_wdata,
    input  wire                 reg_rd,
    output reg  [7:0]           reg_rdata,
    output reg                  reg_rd_valid,
    output reg  [3:0]           status_addr,
    output reg  [7:0]           status_data,
    output reg                  status_valid,
    // PHY core events
    input  wire                 bus_reset,
    input  wire                 self_id_done,
    input  wire [NODE_ID_W-1:0] self_id_node,
    input  wire                 tree_id_root,
    input  wire                 txrx_busy,
    input  wire                 cfg_pkt_valid,
    input  wire                 cfg_pkt_set_holdoff,
    input  wire                 cfg_pkt_root_holdoff,
    input  wire                 cfg_pkt_set_gap,
    input  wire [GAP_W-1:0]     cfg_pkt_gap,
    input  wire                 cable_power_pin,
    // Control toward the PHY core
    output wire [NODE_ID_W-1:0] node_identifier,
    output wire                 node_id_valid,
    output wire                 root_holdoff,
    output wire [GAP_W-1:0]     gap_count,
    output reg                  start_long_bus_reset,
    output wire                 link_ctrl,
    output wire [2:0]           page_select,
    output wire [3:0]           port_select
);

    reg  [NODE_ID_W-1:0] node_id_q;
    reg                  id_valid_q;
    reg                  root_q;
    reg                  holdoff_q;
    reg                  long_reset_q;
    reg  [GAP_W-1:0]     gap_q;
    reg                  reset_seen_q;
    reg                  link_ctrl_q;
    reg  [7:0]           intr_ctl_q;
    reg  [7:0]           legacy_q;
    reg  [7:0]           page_port_q;
    reg  [7:0]           base_rd;
    reg  [7:0]           rd_mux;
    wire                 cable_power_ok;
    wire [7:0]           paged_rd;
    wire                 base_hit;
    wire                 wr_base;
    wire                 wr_reg1;
    wire                 cfg_holdoff;
    wire                 cfg_gap;
    wire                 gap_written;
    wire [7:0]           reg0_image;
    wire                 root_next;
    wire                 long_reset_go;

    // Cable sense is a pin; it reads low for two edges after reset
    level_sync #(
        .WIDTH (1)
    ) u_cable_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (cable_power_pin),
        .sync_out (cable_power_ok)
    );

    // Base versus paged split on the top address bit
    assign base_hit = ~reg_addr[3]; // [RQ1] [RQ2]
    assign wr_base  = reg_wr & base_hit;
    assign wr_reg1  = wr_base & (reg_addr == `ADDR_ROOT_HOLDOFF_RESET_GAP);

    // Writes to a reserved page are dropped inside the paged store
    paged_store #(
        .DATA_W (8)
    ) u_paged (
        .core_clk (core_clk),
        .rst      (rst),
        .page     (page_port_q[`PAGE_MSB:`PAGE_LSB]), // [RQ4]
        .index    (reg_addr[2:0]),
        .wr_en    (reg_wr & reg_addr[3]), // [RQ3]
        .wr_data  (reg_wdata),
        .rd_data  (paged_rd)
    );

    assign cfg_holdoff = cfg_pkt_valid & cfg_pkt_set_holdoff;
    assign cfg_gap     = cfg_pkt_valid & cfg_pkt_set_gap;
    assign gap_written = wr_reg1 | cfg_gap;

    // Node identity and root flag; a set in the reset cycle wins
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            node_id_q  <= {NODE_ID_W{1'b0}};
            id_valid_q <= 1'b0;
            root_q     <= 1'b0;
        end
        else
        begin
            if (self_id_done)
            begin
                node_id_q  <= self_id_node; // [RQ8]
                id_valid_q <= 1'b1; // [RQ9]
            end
            else if (bus_reset)
                id_valid_q <= 1'b0; // [RQ9]
            if (tree_id_root)
                root_q <= 1'b1; // [RQ10]
            else if (bus_reset)
                root_q <= 1'b0; // [RQ10]
        end
    end

    // Root holdoff ignores bus reset by design, so it carries to next tree-ID
    always @(posedge core_clk)
    begin
        if (rst)
            holdoff_q <= `ROOT_HOLDOFF_RESET; // [RQ13]
        else if (cfg_holdoff)
            holdoff_q <= cfg_pkt_root_holdoff; // [RQ14]
        else if (wr_reg1)
            holdoff_q <= reg_wdata[`ROOT_HOLDOFF_BIT]; // [RQ12]
    end

    // Long reset request: held until the bus reset it causes arrives
    always @(posedge core_clk)
    begin
        if (rst)
            long_reset_q <= 1'b0; // [RQ15]
        else if (wr_reg1 && reg_wdata[`LONG_RESET_BIT])
            long_reset_q <= 1'b1;
        else if (bus_reset)
            long_reset_q <= 1'b0; // [RQ15]
    end

    always @(posedge core_clk)
    begin
        if (rst)
            start_long_bus_reset <= 1'b0;
        else
            start_long_bus_reset <= long_reset_go; // [RQ15]
    end

    // Held off while traffic runs or while the bus reset itself arrives
    assign long_reset_go = long_reset_q & ~txrx_busy & ~bus_reset;

    // Gap count: a write in a reset cycle counts as after the reset
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            gap_q        <= `GAP_RESET; // [RQ16]
            reset_seen_q <= 1'b0;
        end
        else if (gap_written)
        begin
            gap_q        <= cfg_gap ? cfg_pkt_gap
                                    : reg_wdata[`GAP_MSB:`GAP_LSB];
            reset_seen_q <= 1'b0;
        end
        else if (bus_reset)
        begin
            // Later unwritten resets keep reloading the default
            if (reset_seen_q)
                gap_q <= `GAP_RESET; // [RQ16]
            reset_seen_q <= 1'b1;
        end
    end

    // Remaining writable base registers; reserved bits never stored
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            link_ctrl_q <= `LINK_CTRL_RESET;
            intr_ctl_q  <= `INTR_CTL_RESET;
            legacy_q    <= `LEGACY_RESET;
            page_port_q <= `PAGE_PORT_RESET;
        end
        else if (wr_base)
        begin
            case (reg_addr)
                `ADDR_LINK_ACTIVE_POWER_CLASS:
                    link_ctrl_q <= reg_wdata[`LINK_CTRL_BIT];
                `ADDR_INTERRUPT_ENHANCE_CTL:
                    intr_ctl_q <= reg_wdata;
                `ADDR_LEGACY_SPEED_BRIDGE:
                    legacy_q <= reg_wdata & `LEGACY_WRITE_MASK; // [RQ6]
                `ADDR_PAGE_AND_PORT_CHOICE:
                    page_port_q <= reg_wdata & `PAGE_PORT_WRITE_MASK; // [RQ6]
                default:
                    link_ctrl_q <= link_ctrl_q;
            endcase
        end
    end

    // Position 0 lands on data bit 7
    assign reg0_image = {node_id_q, root_q, cable_power_ok}; // [RQ17] [RQ11]

    // Root flag as it stands after this edge, so the status image is current
    assign root_next = tree_id_root | (root_q & ~bus_reset);

    // Base read decode never looks at the page field
    always @*
    begin
        base_rd = 8'h00;
        case (reg_addr[2:0])
            3'h0: base_rd = reg0_image; // [RQ5]
            3'h1: base_rd = {holdoff_q, long_reset_q, gap_q};
            3'h2: base_rd = `EXTENSION_PORT_VALUE;
            3'h3: base_rd = `SPEED_DELAY_VALUE; // [RQ6]
            3'h4: base_rd = {link_ctrl_q, `POWER_INFO_VALUE};
            3'h5: base_rd = intr_ctl_q;
            3'h6: base_rd = legacy_q;
            3'h7: base_rd = page_port_q;
            default: base_rd = 8'h00;
        endcase
        rd_mux = base_hit ? base_rd : paged_rd; // [RQ2] [RQ3]
    end

    always @(posedge core_clk)
    begin
        if (rst)
        begin
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd;
            // Data holds between reads; a same-cycle write is not yet seen
            if (reg_rd)
                reg_rdata <= rd_mux;
        end
    end

    // Unsolicited register 0 transfer marks the identifier as valid.
    // The image uses the incoming identifier so the transfer is current.
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            status_valid <= 1'b0;
            status_addr  <= 4'h0;
            status_data  <= 8'h00;
        end
        else
        begin
            status_valid <= self_id_done; // [RQ9]
            if (self_id_done)
            begin
                status_addr <= `ADDR_NODE_IDENTITY_STATUS;
                status_data <= {self_id_node,
                                root_next,
                                cable_power_ok}; // [RQ9] [RQ17]
            end
        end
    end

    // Core-facing outputs come straight from flops
    assign node_identifier = node_id_q;
    assign node_id_valid   = id_valid_q;
    assign root_holdoff    = holdoff_q;
    assign gap_count       = gap_q;
    assign link_ctrl       = link_ctrl_q;
    assign page_select     = page_port_q[`PAGE_MSB:`PAGE_LSB];
    assign port_select     = page_port_q[`PORT_MSB:`PORT_LSB];

endmodule

`default_nettype wire

// ### phy_base_regs_monitor.sv
// Port checker for the PHY register bank.
// Assumes one core_clk domain and rst synchronous, active high.
`timescale 1ns/100ps
`default_nettype none
module phy_base_regs_monitor #(
    parameter NODE_ID_W = 6,
    parameter GAP_W     = 6
) (
    input wire                 core_clk,
    input wire                 rst,
    input wire [3:0]           reg_addr,
    input wire                 reg_wr,
    input wire [7:0]           reg_wdata,
    input wire                 reg_rd,
    input wire [7:0]           reg_rdata,
    input wire                 reg_rd_valid,
    input wire [3:0]           status_addr,
    input wire [7:0]           status_data,
    input wire                 status_valid,
    input wire                 bus_reset,
    input wire                 self_id_done,
    input wire [NODE_ID_W-1:0] self_id_node,
    input wire                 tree_id_root,
    input wire                 txrx_busy,
    input wire                 cfg_pkt_valid,
    input wire                 root_holdoff,
    input wire [GAP_W-1:0]     gap_count,
    input wire                 node_id_valid,
    input wire                 start_long_bus_reset,
    input wire [2:0]           page_select
);
    wire [2:0] wr_page = reg_wdata[7:5];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_rd_answer: assert property (reg_rd |=> reg_rd_valid)
        else $error("read not answered next cycle");
    chk_no_stray_valid: assert property (!reg_rd |=> !reg_rd_valid)
        else $error("read valid without read");
    chk_status_image: assert property (self_id_done |=> status_valid
        && status_addr == 4'h0 && status_data[7:2] == $past(self_id_node))
        else $error("status transfer wrong");
    chk_id_invalid: assert property (bus_reset && !self_id_done
        |=> !node_id_valid) else $error("node id still valid");
    chk_root_clear: assert property (bus_reset && !tree_id_root ##1
        !tree_id_root ##1 reg_rd && reg_addr == 4'h0 && !tree_id_root
        |=> !reg_rdata[1]) else $error("root flag survived bus reset");
    chk_holdoff_keep: assert property (bus_reset && !cfg_pkt_valid &&
        !reg_wr |=> $stable(root_holdoff)) else $error("holdoff moved");
    chk_long_rst_wait: assert property (txrx_busy [*2]
        |-> !start_long_bus_reset) else $error("long reset during traffic");
    chk_reserved_page: assert property (reg_rd && reg_addr[3] &&
        page_select >= 3'h2 && page_select <= 3'h6 |=> reg_rdata == 8'h00)
        else $error("reserved page not zero");
    chk_page_follow: assert property (reg_wr && reg_addr == 4'h7
        |=> page_select == $past(wr_page)) else $error("page not taken");
    chk_gap_reset: assert property ($fell(rst) |->
        gap_count == 6'h3F && !root_holdoff) else $error("reset values");
endmodule
bind phy_base_regs phy_base_regs_monitor #(.NODE_ID_W(NODE_ID_W),
    .GAP_W(GAP_W)) mon (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .status_addr(status_addr), .status_data(status_data),
    .status_valid(status_valid), .bus_reset(bus_reset),
    .self_id_done(self_id_done), .self_id_node(self_id_node),
    .tree_id_root(tree_id_root), .txrx_busy(txrx_busy),
    .cfg_pkt_valid(cfg_pkt_valid), .root_holdoff(root_holdoff),
    .gap_count(gap_count), .node_id_valid(node_id_valid),
    .start_long_bus_reset(start_long_bus_reset),
    .page_select(page_select));
`default_nettype wire

// ### phy_base_regs_tb_top.sv
// Self-checking bench for the PHY register bank.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module phy_base_regs_tb_top;
    reg         core_clk, rst, bus_reset, self_id_done, tree_id_root;
    reg         txrx_busy, cfg_pkt_valid, cable_power_pin, cfg_hold;
    reg  [5:0]  self_id_node, cfg_pkt_gap, nid;
    reg  [7:0]  d, v;
    reg  [7:0]  mem [0:63];
    reg  [31:0] seed;
    wire [3:0]  reg_addr, status_addr;
    wire [7:0]  reg_wdata, reg_rdata, status_data;
    wire        reg_wr, reg_rd, reg_rd_valid, status_valid;
    wire        node_id_valid, root_holdoff, start_long_bus_reset;
    wire [5:0]  node_identifier, gap_count;
    wire [2:0]  page_select;
    wire [3:0]  port_select;
    wire        link_ctrl;
    integer     fails, n_checks, cyc, i, p;

    phy_base_regs uut (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .status_addr(status_addr), .status_data(status_data),
        .status_valid(status_valid), .bus_reset(bus_reset),
        .self_id_done(self_id_done), .self_id_node(self_id_node),
        .tree_id_root(tree_id_root), .txrx_busy(txrx_busy),
        .cfg_pkt_valid(cfg_pkt_valid), .cfg_pkt_set_holdoff(cfg_pkt_valid),
        .cfg_pkt_root_holdoff(cfg_hold), .cfg_pkt_set_gap(cfg_pkt_valid),
        .cfg_pkt_gap(cfg_pkt_gap), .cable_power_pin(cable_power_pin),
        .node_identifier(node_identifier), .node_id_valid(node_id_valid),
        .root_holdoff(root_holdoff), .gap_count(gap_count),
        .start_long_bus_reset(start_long_bus_reset), .link_ctrl(link_ctrl),
        .page_select(page_select), .port_select(port_select));
    link_model lm (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));

    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
    begin
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    end
    endfunction
    // Reset image with the cable sense held high
    function [7:0] rst_val(input [3:0] a);
        case (a)
            4'h0: rst_val = 8'h01;
            4'h1: rst_val = 8'h3F;
            4'h2: rst_val = 8'hE3;
            4'h3: rst_val = 8'hE0;
            4'h4: rst_val = 8'h80;
            default: rst_val = 8'h00;
        endcase
    endfunction
    function [7:0] wmask(input [3:0] a);
        case (a)
            4'h4: wmask = 8'h80;
            4'h5: wmask = 8'hFF;
            4'h6: wmask = 8'hFC;
            4'h7: wmask = 8'hEF;
            default: wmask = 8'h00;
        endcase
    endfunction
    task chk(input [8*8-1:0] name, input [7:0] seen, input [7:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, seen);
        end
    end
    endtask
    task rchk(input [3:0] a, input [7:0] e);
    begin
        lm.rd(a, v);
        chk("rdata", v, e);
    end
    endtask
    task pulse_reset;
    begin
        @(negedge core_clk);
        bus_reset = 1'b1;
        @(negedge core_clk);
        bus_reset = 1'b0;
    end
    endtask
    // Holdoff changes through a configuration packet or a register 1 write
    task cfg_send(input h, input [5:0] g);
    begin
        @(negedge core_clk);
        {cfg_pkt_valid, cfg_hold, cfg_pkt_gap} = {1'b1, h, g};
        @(negedge core_clk);
        cfg_pkt_valid = 1'b0;
    end
    endtask
    task summarize;
    begin
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Whole run is near 540 cycles
    always @(posedge core_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 5000)
        begin
            fails = fails + 1;
            summarize;
        end
    end

    initial
    begin
        {fails, n_checks, cyc} = 0;
        seed = 32'h0001_4F32;
        {rst, cable_power_pin} = 2'b11;
        {bus_reset, self_id_done, tree_id_root, txrx_busy} = 4'h0;
        {cfg_pkt_valid, cfg_hold, self_id_node, cfg_pkt_gap} = 14'h0000;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        for (i = 0; i < 8; i = i + 1)
            rchk(i[3:0], rst_val(i[3:0]));
        for (i = 0; i < 8; i = i + 1)
        begin
            seed = xs(seed);
            d = seed[7:0];
            if (i != 1)
            begin
                lm.wr(i[3:0], d);
                rchk(i[3:0], (rst_val(i[3:0]) & ~wmask(i[3:0])) |
                    (d & wmask(i[3:0])));
                if (i == 4)
                    chk("lctrl", {7'h00, link_ctrl}, {7'h00, d[7]});
                if (i == 7)
                    chk("port", {4'h0, port_select}, {4'h0, d[3:0]});
            end
        end
        // Pages are switched between every group to catch a stuck page
        for (p = 0; p < 128; p = p + 1)
        begin
            if (p % 8 == 0)
                lm.wr(4'h7, {p[5:3], 5'h00});
            if (p < 64)
            begin
                seed = xs(seed);
                mem[p] = seed[7:0];
                lm.wr({1'b1, p[2:0]}, mem[p]);
            end
            else
            begin
                rchk(4'h2, 8'hE3);
                rchk({1'b1, p[2:0]}, (p[5:3] > 1 && p[5:3] < 7) ?
                    8'h00 : mem[p[5:0]]);
            end
        end
        seed = xs(seed);
        nid = seed[5:0];
        @(negedge core_clk);
        tree_id_root = 1'b1;
        @(negedge core_clk);
        {tree_id_root, self_id_done, self_id_node} = {2'b01, nid};
        @(negedge core_clk);
        {self_id_done, self_id_node} = {1'b0, ~nid};
        chk("status", status_data, {nid, 2'b11});
        chk("valid", {status_valid, node_id_valid, 2'b00, status_addr},
            8'hC0);
        chk("node id", {2'b00, node_identifier}, {2'b00, nid});
        lm.wr(4'h0, ~{nid, 2'b11});
        rchk(4'h0, {nid, 2'b11});
        pulse_reset;
        chk("valid", {7'h00, node_id_valid}, 8'h00);
        rchk(4'h0, {nid, 2'b01});
        seed = xs(seed);
        cfg_send(1'b1, {1'b0, seed[4:0]});
        rchk(4'h1, {3'b100, seed[4:0]});
        for (i = 0; i < 2; i = i + 1)
        begin
            pulse_reset;
            rchk(4'h1, i ? 8'hBF : {3'b100, seed[4:0]});
        end
        txrx_busy = 1'b1;
        lm.wr(4'h1, 8'hFF); // Holdoff rewritten as 1; also requests a long reset
        repeat (3) @(negedge core_clk);
        chk("long rst", {7'h00, start_long_bus_reset}, 8'h00);
        txrx_busy = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("long rst", {7'h00, start_long_bus_reset}, 8'h01);
        pulse_reset;
        chk("long rst", {7'h00, start_long_bus_reset}, 8'h00);
        rchk(4'h1, 8'hBF);
        cfg_send(1'b0, 6'h15);
        rchk(4'h1, 8'h15);
        cfg_send(1'b1, 6'h2A);
        rchk(4'h1, 8'hAA);
        for (i = 0; i < 6; i = i + 1)
        begin
            seed = xs(seed);
            cable_power_pin = seed[0];
            repeat (3) @(negedge core_clk);
            lm.rd(4'h0, v);
            chk("cable", {7'h00, v[0]}, {7'h00, seed[0]});
        end
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        rchk(4'h1, 8'h3F);
        summarize;
    end
endmodule
`default_nettype wire

// ### phy_regs_map.vh
// Register map constants for the cable PHY base and paged register bank.
// Assumes inclusion by bare name; holds definitions only.
`ifndef PHY_REGS_MAP_VH
`define PHY_REGS_MAP_VH

// Base register addresses (four-bit register address space)
`define ADDR_NODE_IDENTITY_STATUS     4'h0
`define ADDR_ROOT_HOLDOFF_RESET_GAP   4'h1
`define ADDR_EXTENSION_PORT_COUNT     4'h2
`define ADDR_SPEED_DELAY_INFO         4'h3
`define ADDR_LINK_ACTIVE_POWER_CLASS  4'h4
`define ADDR_INTERRUPT_ENHANCE_CTL    4'h5
`define ADDR_LEGACY_SPEED_BRIDGE      4'h6
`define ADDR_PAGE_AND_PORT_CHOICE     4'h7

// Bit position 0 of each register is data bit 7 on the link side
// Register 0
`define NODE_ID_MSB                   7
`define NODE_ID_LSB                   2
`define ROOT_FLAG_BIT                 1
`define CABLE_POWER_BIT               0
// Register 1
`define ROOT_HOLDOFF_BIT              7
`define LONG_RESET_BIT                6
`define GAP_MSB                       5
`define GAP_LSB                       0
// Register 4
`define LINK_CTRL_BIT                 7
// Register 6 reserved low bits
`define LEGACY_WRITE_MASK             8'hFC
// Register 7
`define PAGE_MSB                      7
`define PAGE_LSB                      5
`define PORT_MSB                      3
`define PORT_LSB                      0
`define PAGE_PORT_WRITE_MASK          8'hEF

// Fixed read-only contents
`define EXTENSION_PORT_VALUE          8'hE3
`define SPEED_DELAY_VALUE             8'hE0
`define POWER_INFO_VALUE              7'h00

// Reset values
`define GAP_RESET                     6'h3F
`define ROOT_HOLDOFF_RESET            1'b0
`define LINK_CTRL_RESET               1'b1
`define INTR_CTL_RESET                8'h00
`define LEGACY_RESET                  8'h00
`define PAGE_PORT_RESET               8'h00
`define PAGED_RESET                   8'h00

// Pages that hold storage; pages 2 through 6 are reserved
`define PAGE_PORT_STATUS              3'h0
`define PAGE_VENDOR_ID                3'h1
`define PAGE_VENDOR_DEP               3'h7

// Long bus reset duration, informational for the arbitration core
`define LONG_RESET_US                 166
`define CLK_MHZ                       100
`define LONG_RESET_CYCLES             (`LONG_RESET_US * `CLK_MHZ)

`endif
